// file: rtl/lpwm_bank.sv
`timescale 1ns/1ps
module lpwm_bank (
  // System
  input  wire logic                                      clk,
  input  wire logic                                      reset,
  input  wire logic                                      ce,
  // Serial link
  input  wire logic                                      scl,
  input  wire logic                                      sda_in,
  output logic                                           sda_out,
  output logic                                           sda_oe,
  // Address strap
  input  wire logic [1:0]                                addr_strap,
  // Channel outputs
  output logic [lpwm_pkg::NUM_CH-1:0]                    led_sink_outputs,
  output logic [lpwm_pkg::NUM_CH*lpwm_pkg::SCALE_W-1:0]  current_scale_sel,
  output logic                                           soft_power_down_n
);
  import lpwm_pkg::*;

  logic                link_tgl;
  logic                link_bit;
  logic                tgl_s1;
  logic                tgl_s2;
  logic                tgl_s3;
  logic                tgl_seen;
  logic [PIN_W-1:0]    pin_s1;
  logic [PIN_W-1:0]    pin_s2;
  logic [PIN_W-1:0]    pin_s3;
  logic [PIN_W-1:0]    pin_f;
  logic [PIN_W-1:0]    pin_p;
  logic                bit_evt;
  logic                start_c;
  logic                stop_c;
  logic                scl_fall;
  logic [1:0]          strap_f;
  lpwm_state_t         state;
  logic [3:0]          bit_cnt;
  logic [6:0]          shift;
  logic [7:0]          byte_val;
  logic                byte_done;
  logic                addr_match;
  logic                ack_pend;
  logic                wr_stb;
  logic [7:0]          ptr;
  logic                soft_rst;
  logic                in_duty;
  logic                in_ctl;
  logic [IDX_W-1:0]    duty_idx;
  logic [IDX_W-1:0]    ctl_idx;
  logic [DUTY_W-1:0]   duty_sh  [NUM_CH];
  logic [DUTY_W-1:0]   duty_act [NUM_CH];
  logic [CTL_W-1:0]    ctl_sh   [NUM_CH];
  logic [CTL_W-1:0]    ctl_act  [NUM_CH];
  logic                all_dis;
  logic [DUTY_W-1:0]   pwm_cnt;

  // Link side: sample each data bit on the rising clock and flag it
  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      link_tgl <= 1'b0;
      link_bit <= 1'b0;
    end else begin
      link_bit <= sda_in;
      link_tgl <= ~link_tgl;
    end
  end

  // Bit flag crossing; the sampled bit stays stable for a whole link period
  always_ff @(posedge clk) begin
    if (reset) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (ce) begin
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // A flag change counts once the second and third stages agree
  assign bit_evt = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen);

  // Pin synchroniser with agreement filter
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_f  <= PIN_IDLE;
      pin_p  <= PIN_IDLE;
    end else if (ce) begin
      pin_s1 <= {addr_strap, sda_in, scl};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < PIN_W; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_f[i] <= pin_s3[i];
        end
      end
      pin_p <= pin_f;
    end
  end

  assign strap_f  = pin_f[PIN_STRAP_LSB +: 2];
  assign start_c  = pin_f[PIN_SCL] && pin_p[PIN_SCL] && pin_p[PIN_SDA] && !pin_f[PIN_SDA];
  assign stop_c   = pin_f[PIN_SCL] && pin_p[PIN_SCL] && !pin_p[PIN_SDA] && pin_f[PIN_SDA];
  assign scl_fall = pin_p[PIN_SCL] && !pin_f[PIN_SCL];

  // Byte assembly, MSB first
  assign byte_val   = {shift, link_bit};
  assign byte_done  = bit_evt && !start_c && !stop_c && (state != ST_IDLE) && (bit_cnt == BIT_LAST);
  assign addr_match = (byte_val == {TARGET_ADDR_HI, strap_f, WRITE_DIR});
  assign wr_stb     = byte_done && (state == ST_DATA);

  // Transfer framing and acknowledge
  always_ff @(posedge clk) begin
    if (reset) begin
      state    <= ST_IDLE;
      bit_cnt  <= BIT_FIRST;
      shift    <= '0;
      ack_pend <= 1'b0;
      sda_oe   <= 1'b0;
      tgl_seen <= 1'b0;
    end else if (ce) begin
      if (bit_evt) begin
        tgl_seen <= tgl_s3;
      end
      if (start_c) begin
        state    <= ST_ADDR;
        bit_cnt  <= BIT_FIRST;
        ack_pend <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (stop_c) begin
        state    <= ST_IDLE;
        bit_cnt  <= BIT_FIRST;
        ack_pend <= 1'b0;
        sda_oe   <= 1'b0;
      end else begin
        if (bit_evt && state != ST_IDLE) begin
          if (bit_cnt == BIT_ACK) begin
            bit_cnt <= BIT_FIRST;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shift   <= byte_val[6:0];
          end
        end
        if (byte_done) begin
          unique case (state)
            ST_ADDR: begin
              if (addr_match) begin
                state    <= ST_REG;
                ack_pend <= 1'b1;
              end else begin
                state    <= ST_IDLE;
              end
            end
            ST_REG: begin
              state    <= ST_DATA;
              ack_pend <= 1'b1;
            end
            ST_DATA: begin
              state    <= ST_DATA;
              ack_pend <= 1'b1;
            end
            ST_IDLE: begin
              state    <= ST_IDLE;
            end
          endcase
        end
        if (scl_fall) begin
          if (ack_pend) begin
            sda_oe   <= 1'b1;
            ack_pend <= 1'b0;
          end else if (bit_cnt == BIT_FIRST) begin
            sda_oe   <= 1'b0;
          end
        end
      end
    end
  end

  assign sda_out = 1'b0;

  // Register pointer
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr <= OFS_POWER;
    end else if (ce && byte_done) begin
      if (state == ST_REG) begin
        ptr <= byte_val;
      end else if (state == ST_DATA) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  // Write decode
  assign in_duty  = (ptr >= OFS_DUTY_FIRST) && (ptr <= OFS_DUTY_LAST);
  assign in_ctl   = (ptr >= OFS_CTL_FIRST) && (ptr <= OFS_CTL_LAST);
  assign duty_idx = IDX_W'(ptr - OFS_DUTY_FIRST);
  assign ctl_idx  = IDX_W'(ptr - OFS_CTL_FIRST);
  assign soft_rst = wr_stb && (ptr == OFS_SOFT_RST) && (byte_val == TRIGGER_VAL);

  // Register file
  always_ff @(posedge clk) begin
    if (reset || (ce && soft_rst)) begin
      soft_power_down_n <= POWER_RST;
      all_dis           <= ALL_DIS_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_sh[i]  <= DUTY_RST;
        duty_act[i] <= DUTY_RST;
        ctl_sh[i]   <= CTL_RST;
        ctl_act[i]  <= CTL_RST;
      end
    end else if (ce && wr_stb) begin
      if (ptr == OFS_POWER) begin
        soft_power_down_n <= byte_val[POWER_BIT];
      end
      if (in_duty) begin
        duty_sh[duty_idx] <= byte_val;
      end
      if (in_ctl) begin
        ctl_sh[ctl_idx] <= byte_val[CTL_W-1:0];
      end
      if (ptr == OFS_COMMIT && byte_val == TRIGGER_VAL) begin
        duty_act <= duty_sh;
        ctl_act  <= ctl_sh;
      end
      if (ptr == OFS_ALL_DIS) begin
        all_dis <= byte_val[ALL_DIS_BIT];
      end
    end
  end

  // Duty carrier
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_cnt <= '0;
    end else if (ce) begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // Channel outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      led_sink_outputs  <= '0;
      current_scale_sel <= '0;
    end else if (ce) begin
      for (int i = 0; i < NUM_CH; i++) begin
        led_sink_outputs[i] <= soft_power_down_n && !all_dis && ctl_act[i][EN_BIT]
                               && (pwm_cnt < duty_act[i]);
        current_scale_sel[i*SCALE_W +: SCALE_W] <= ctl_act[i][SCALE_LSB +: SCALE_W];
      end
    end
  end

  // Checks
  property p_ptr_step;
    @(posedge clk) disable iff (reset) (ce && wr_stb) |=> (ptr == $past(ptr) + 8'h01);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

  property p_burst_stays;
    @(posedge clk) disable iff (reset) (ce && wr_stb) |=> (state == ST_DATA) && ack_pend;
  endproperty
  a_burst_stays: assert property (p_burst_stays) else $error("burst left data phase");

  property p_power_write;
    @(posedge clk) disable iff (reset) (ce && wr_stb && ptr == OFS_POWER)
      |=> (soft_power_down_n == $past(byte_val[POWER_BIT]));
  endproperty
  a_power_write: assert property (p_power_write) else $error("power bit not stored");

  property p_power_gates;
    @(posedge clk) disable iff (reset) (ce && !soft_power_down_n) |=> (led_sink_outputs == '0);
  endproperty
  a_power_gates: assert property (p_power_gates) else $error("output lit while powered down");

  property p_duty_on;
    @(posedge clk) disable iff (reset)
      (ce && soft_power_down_n && !all_dis && ctl_act[0][EN_BIT] && pwm_cnt < duty_act[0])
      |=> led_sink_outputs[0];
  endproperty
  a_duty_on: assert property (p_duty_on) else $error("channel dark inside duty");

  property p_shadow_hold;
    @(posedge clk) disable iff (reset) (ce && wr_stb && (in_duty || in_ctl))
      |=> $stable(duty_act[0]) && $stable(ctl_act[0]);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("active value moved without commit");

  property p_commit;
    @(posedge clk) disable iff (reset) (ce && wr_stb && ptr == OFS_COMMIT && byte_val == TRIGGER_VAL)
      |=> (duty_act[0] == $past(duty_sh[0])) && (ctl_act[NUM_CH-1] == $past(ctl_sh[NUM_CH-1]));
  endproperty
  a_commit: assert property (p_commit) else $error("commit did not copy shadows");

  property p_scale_out;
    @(posedge clk) disable iff (reset)
      (ce && wr_stb && ptr == OFS_COMMIT && byte_val == TRIGGER_VAL) ##1 ce
      |=> (current_scale_sel[SCALE_W-1:0] == $past(ctl_sh[0][SCALE_LSB +: SCALE_W], 2));
  endproperty
  a_scale_out: assert property (p_scale_out) else $error("scale not presented after commit");

  property p_chan_off;
    @(posedge clk) disable iff (reset) (ce && !ctl_act[0][EN_BIT]) |=> !led_sink_outputs[0];
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("disabled channel lit");

  property p_all_dis;
    @(posedge clk) disable iff (reset) (ce && all_dis) |=> (led_sink_outputs == '0);
  endproperty
  a_all_dis: assert property (p_all_dis) else $error("output lit under global disable");

  property p_soft_rst;
    @(posedge clk) disable iff (reset) (ce && soft_rst)
      |=> (duty_sh[0] == DUTY_RST) && (ctl_act[0] == CTL_RST) && !soft_power_down_n && !all_dis;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset left state");

  property p_addr_nack;
    @(posedge clk) disable iff (reset) (ce && byte_done && state == ST_ADDR && !addr_match)
      |=> (state == ST_IDLE) && !ack_pend;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

  property p_unmapped;
    @(posedge clk) disable iff (reset) (ce && wr_stb && ptr > OFS_ALL_DIS && ptr < OFS_SOFT_RST)
      |=> $stable(soft_power_down_n) && $stable(all_dis) && $stable(duty_sh[0]) && ack_pend;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state");

  c_burst:  cover property (@(posedge clk) disable iff (reset) wr_stb ##[1:400] wr_stb);
  c_commit: cover property (@(posedge clk) disable iff (reset)
                            wr_stb && ptr == OFS_COMMIT && byte_val == TRIGGER_VAL);
  c_srst:   cover property (@(posedge clk) disable iff (reset) soft_rst);
  c_nack:   cover property (@(posedge clk) disable iff (reset) byte_done && state == ST_ADDR && !addr_match);

endmodule

// file: rtl/lpwm_pkg.sv
package lpwm_pkg;

  // Channel array
  localparam int NUM_CH    = 36;
  localparam int IDX_W     = 6;
  localparam int DUTY_W    = 8;
  localparam int CTL_W     = 3;
  localparam int SCALE_W   = 2;

  // Register offsets
  localparam logic [7:0] OFS_POWER      = 8'h00;
  localparam logic [7:0] OFS_DUTY_FIRST = 8'h01;
  localparam logic [7:0] OFS_DUTY_LAST  = 8'h24;
  localparam logic [7:0] OFS_COMMIT     = 8'h25;
  localparam logic [7:0] OFS_CTL_FIRST  = 8'h26;
  localparam logic [7:0] OFS_CTL_LAST   = 8'h49;
  localparam logic [7:0] OFS_ALL_DIS    = 8'h4a;
  localparam logic [7:0] OFS_SOFT_RST   = 8'h4f;
  localparam logic [7:0] TRIGGER_VAL    = 8'h00;

  // Field positions
  localparam int POWER_BIT   = 0;
  localparam int EN_BIT      = 0;
  localparam int SCALE_LSB   = 1;
  localparam int ALL_DIS_BIT = 0;

  // Reset values
  localparam logic [DUTY_W-1:0] DUTY_RST    = 8'h00;
  localparam logic [CTL_W-1:0]  CTL_RST     = 3'h0;
  localparam logic              POWER_RST   = 1'b0;
  localparam logic              ALL_DIS_RST = 1'b0;

  // Target address and link framing
  localparam logic [4:0] TARGET_ADDR_HI = 5'h0f;
  localparam logic       WRITE_DIR      = 1'b0;
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [3:0] BIT_FIRST      = 4'h0;

  // Pin synchroniser layout {strap[1:0], sda, scl}
  localparam int         PIN_W    = 4;
  localparam int         PIN_SCL  = 0;
  localparam int         PIN_SDA  = 1;
  localparam int         PIN_STRAP_LSB = 2;
  localparam logic [3:0] PIN_IDLE = 4'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_REG  = 2'b10,
    ST_DATA = 2'b11
  } lpwm_state_t;

endpackage

// file: dv/lpwm_master.sv
`timescale 1ns/1ps
module lpwm_master (
  // Link pins
  output logic      scl,
  output logic      sda_drive,
  // Resolved data wire
  input  wire logic sda_line
);
  localparam realtime QTR = 31.25;

  logic [7:0] bytes [0:3];

  // Clock stands high and data released while no frame runs
  initial begin
    scl = 1'b1;
    sda_drive = 1'b1;
  end

  // One byte, then the acknowledge clock
  task automatic put_byte(input logic [7:0] b, inout int nacks);
    for (int i = 7; i >= 0; i--) begin
      #QTR sda_drive = b[i];
      #QTR scl = 1'b1;
      #(2*QTR) scl = 1'b0;
    end
    #QTR sda_drive = 1'b1;
    #QTR scl = 1'b1;
    if (sda_line !== 1'b0) begin
      nacks++;
    end
    #(2*QTR) scl = 1'b0;
  endtask

  // Start, target address, register offset, data bytes, stop
  task automatic write_burst(input logic [7:0] dev, input logic [7:0] ofs, input int n, output int nacks);
    nacks = 0;
    sda_drive = 1'b0;
    #(2*QTR) scl = 1'b0;
    put_byte(dev, nacks);
    put_byte(ofs, nacks);
    for (int k = 0; k < n; k++) begin
      put_byte(bytes[k], nacks);
    end
    #QTR sda_drive = 1'b0;
    #QTR scl = 1'b1;
    #(2*QTR) sda_drive = 1'b1;
    #(4*QTR);
  endtask
endmodule

// file: dv/lpwm_bank_tb.sv
`timescale 1ns/1ps
module lpwm_bank_tb;
  import lpwm_pkg::*;

  localparam logic [1:0] STRAP = 2'b10;
  localparam logic [7:0] DEV   = {TARGET_ADDR_HI, STRAP, WRITE_DIR};

  logic                        clk;
  logic                        reset;
  logic                        ce;
  logic                        scl;
  logic                        sda_drive;
  logic                        sda_line;
  logic                        sda_out;
  logic                        sda_oe;
  logic [1:0]                  addr_strap;
  logic [NUM_CH-1:0]           led_sink_outputs;
  logic [NUM_CH*SCALE_W-1:0]   current_scale_sel;
  logic                        soft_power_down_n;
  int                          fails;
  int                          checks;

  // Open-drain data wire with pull-up
  assign sda_line = sda_oe ? (sda_drive & sda_out) : sda_drive;

  lpwm_bank i_dut (
    .clk               (clk),
    .reset             (reset),
    .ce                (ce),
    .scl               (scl),
    .sda_in            (sda_line),
    .sda_out           (sda_out),
    .sda_oe            (sda_oe),
    .addr_strap        (addr_strap),
    .led_sink_outputs  (led_sink_outputs),
    .current_scale_sel (current_scale_sel),
    .soft_power_down_n (soft_power_down_n)
  );

  lpwm_master i_master (
    .scl       (scl),
    .sda_drive (sda_drive),
    .sda_line  (sda_line)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Burst write of n bytes taken from d, most significant byte first
  task automatic wr(input logic [7:0] ofs, input int n, input logic [31:0] d, input logic [7:0] dev);
    int nk;
    for (int k = 0; k < 4; k++) begin
      i_master.bytes[k] = d[31-8*k -: 8];
    end
    i_master.write_burst(dev, ofs, n, nk);
    check(128'(nk), (dev === DEV) ? 128'h0 : 128'(n + 2), "acknowledges");
    repeat (4) @(negedge clk);
  endtask

  // High cycles of channels 1 to 4 over one full pwm period
  task automatic duties(input logic [31:0] exp);
    int n [4];
    for (int c = 0; c < 4; c++) begin
      n[c] = 0;
    end
    repeat (256) begin
      @(negedge clk);
      for (int c = 0; c < 4; c++) begin
        n[c] += (led_sink_outputs[c] === 1'b1) ? 1 : 0;
      end
    end
    for (int c = 0; c < 4; c++) begin
      check(128'(n[c]), 128'(exp[31-8*c -: 8]), "duty count");
    end
  endtask

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  initial begin
    fails = 0;
    checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    addr_strap = STRAP;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check({led_sink_outputs, current_scale_sel, soft_power_down_n}, 128'h0, "reset outputs");
    wr(OFS_POWER, 1, 32'h01000000, DEV);
    check(soft_power_down_n, 1'b1, "power bit");
    wr(OFS_DUTY_FIRST, 4, 32'h80ff0012, DEV);
    wr(OFS_CTL_FIRST, 4, 32'h01030507, DEV);
    check(current_scale_sel, 72'h0, "staged scale");
    duties(32'h0);
    wr(OFS_COMMIT, 1, 32'h0, DEV);
    check(current_scale_sel[7:0], 8'he4, "scale codes");
    duties(32'h80ff0012);
    wr(OFS_CTL_FIRST + 8'h01, 1, 32'h06000000, DEV);
    wr(OFS_COMMIT, 1, 32'h0, DEV);
    check(current_scale_sel[3:2], 2'h3, "scale channel two");
    duties(32'h80000012);
    wr(OFS_ALL_DIS, 1, 32'h01000000, DEV);
    duties(32'h0);
    wr(OFS_ALL_DIS, 1, 32'h0, DEV);
    duties(32'h80000012);
    wr(OFS_POWER, 1, 32'h0, DEV);
    check(soft_power_down_n, 1'b0, "power bit");
    duties(32'h0);
    wr(OFS_POWER, 1, 32'h01000000, DEV);
    wr(OFS_DUTY_FIRST, 1, 32'h20000000, DEV);
    wr(8'h4b, 4, 32'h01010101, DEV);
    wr(8'h50, 1, 32'h01000000, DEV);
    wr(OFS_COMMIT, 1, 32'h05000000, DEV);
    duties(32'h80000012);
    wr(OFS_COMMIT, 1, 32'h0, DEV);
    duties(32'h20000012);
    wr(OFS_POWER, 1, 32'h0, {TARGET_ADDR_HI, 2'b01, WRITE_DIR});
    wr(OFS_POWER, 1, 32'h0, {TARGET_ADDR_HI, STRAP, 1'b1});
    check(soft_power_down_n, 1'b1, "foreign address");
    wr(OFS_SOFT_RST, 1, 32'h0, DEV);
    check({led_sink_outputs, current_scale_sel, soft_power_down_n}, 128'h0, "soft reset");
    wr(OFS_POWER, 1, 32'h01000000, DEV);
    wr(OFS_COMMIT, 1, 32'h0, DEV);
    check(current_scale_sel, 72'h0, "cleared shadows");
    duties(32'h0);
    wr(OFS_POWER, 1, 32'h01000000, DEV);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check(soft_power_down_n, 1'b0, "power after reset");
    report_and_stop();
  end
endmodule
